// ### rtl/pot_host.sv
// two-wire bus master for the potentiometer, ordered over AXI4-Lite
// one transfer at a time; the slave is assumed never to stretch the clock
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module pot_host
    import pot_link_pkg::*;
#(
    parameter int QTR = SCL_QUARTER_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // AXI4-Lite slave
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // link
    pot_link_if.host link
);
    if (QTR < 8) begin : g_bad_qtr
        $error("QTR too small for the slave's sampling delay");
    end

    typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} host_state_e;

    host_state_e state;
    logic awHeld, wHeld;
    logic [7:0] awAddrQ;
    logic [31:0] wDataQ;
    logic [3:0] wStrbQ;
    logic readMode, noData, busy, nack, sclReg, sdaLow;
    logic [6:0] slaveAddr;
    logic [7:0] instrByte, dataByte, rxShift, rxFirst, rxSecond;
    logic [15:0] qCnt;
    logic [1:0] phase, byteIdx;
    logic [3:0] bitIdx;
    logic sdaLevel;

    line_sampler u_sampler (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .sclPin(link.scl),
        .sdaPin(link.sda),
        .sclLevel(),
        .sdaLevel(sdaLevel),
        .sclRise(),
        .sclFall(),
        .startSeen(),
        .stopSeen()
    );

    assign awready = !awHeld;
    assign wready = !wHeld;
    assign arready = !rvalid;
    wire doWrite = awHeld && wHeld && !bvalid;
    wire wrCtrl = doWrite && awAddrQ == REG_CTRL;
    wire wrSlave = doWrite && awAddrQ == REG_SLAVE;
    wire wrTx = doWrite && awAddrQ == REG_TX;
    wire wrMapped = wrCtrl || wrSlave || wrTx || awAddrQ == REG_STATUS || awAddrQ == REG_RX;
    wire goReq = wrCtrl && wStrbQ[0] && wDataQ[CTRL_GO_BIT] && !busy;
    wire rdMapped = araddr == REG_CTRL || araddr == REG_SLAVE || araddr == REG_TX
                    || araddr == REG_STATUS || araddr == REG_RX;
    wire [31:0] readWord = (araddr == REG_CTRL) ? {29'h0, noData, readMode, 1'b0} :
                           (araddr == REG_SLAVE) ? {25'h0, slaveAddr} :
                           (araddr == REG_TX) ? {16'h0, instrByte, dataByte} :
                           (araddr == REG_STATUS) ? {30'h0, nack, busy} :
                           (araddr == REG_RX) ? {16'h0, rxFirst, rxSecond} : 32'h0;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddrQ <= 8'h00;
            wDataQ <= 32'h0;
            wStrbQ <= 4'h0;
            bvalid <= 1'b0;
            bresp <= AXI_OKAY;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= AXI_OKAY;
        end else begin
            if (awvalid && awready) begin
                awHeld <= 1'b1;
                awAddrQ <= awaddr;
            end
            if (wvalid && wready) begin
                wHeld <= 1'b1;
                wDataQ <= wdata;
                wStrbQ <= wstrb;
            end
            if (doWrite) begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wrMapped ? AXI_OKAY : AXI_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rdata <= readWord;
                rresp <= rdMapped ? AXI_OKAY : AXI_SLVERR;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // settings are frozen while a transfer runs
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            readMode <= 1'b0;
            noData <= 1'b0;
            slaveAddr <= SLAVE_RESET;
            instrByte <= 8'h00;
            dataByte <= WIPER_MIDSCALE;
        end else if (!busy) begin
            if (wrCtrl && wStrbQ[0]) begin
                readMode <= wDataQ[CTRL_READ_BIT];
                noData <= wDataQ[CTRL_NODATA_BIT];
            end
            if (wrSlave && wStrbQ[0]) begin
                slaveAddr <= wDataQ[6:0];
            end
            if (wrTx && wStrbQ[0]) begin
                dataByte <= wDataQ[7:0];
            end
            if (wrTx && wStrbQ[1]) begin
                instrByte <= {wDataQ[15:13], 1'b0, wDataQ[11:8]};
            end
        end
    end

    wire isRx = readMode && byteIdx != 2'h0;
    wire lastByte = (readMode || !noData) ? byteIdx == 2'h2 : byteIdx == 2'h1;
    wire [7:0] txByte = (byteIdx == 2'h0) ? {slaveAddr, readMode} :
                        (byteIdx == 2'h1) ? instrByte : dataByte;
    wire tick = busy && qCnt == 16'(QTR - 1);

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state <= H_IDLE;
            busy <= 1'b0;
            nack <= 1'b0;
            sclReg <= 1'b1;
            sdaLow <= 1'b0;
            qCnt <= 16'h0;
            phase <= 2'h0;
            byteIdx <= 2'h0;
            bitIdx <= 4'h0;
            rxShift <= 8'h00;
            rxFirst <= 8'h00;
            rxSecond <= 8'h00;
        end else if (goReq) begin
            state <= H_START;
            busy <= 1'b1;
            nack <= 1'b0;
            qCnt <= 16'h0;
            phase <= 2'h0;
            byteIdx <= 2'h0;
            bitIdx <= 4'h0;
        end else if (busy) begin
            qCnt <= tick ? 16'h0 : qCnt + 16'h1;
            if (tick) begin
                phase <= phase + 2'h1;
                case (state)
                    H_START: begin
                        if (phase == 2'h1) sdaLow <= 1'b1;
                        if (phase == 2'h2) sclReg <= 1'b0;
                        if (phase == 2'h3) state <= H_BIT;
                    end
                    H_BIT: begin
                        // data moves only mid-way through the clock-low half
                        if (phase == 2'h0 && bitIdx != ACK_SLOT) begin
                            sdaLow <= !isRx && !txByte[3'(LAST_DATA_BIT - bitIdx)];
                        end
                        if (phase == 2'h0 && bitIdx == ACK_SLOT) begin
                            sdaLow <= isRx && !lastByte;
                        end
                        if (phase == 2'h1) sclReg <= 1'b1;
                        if (phase == 2'h2 && bitIdx != ACK_SLOT && isRx) begin
                            rxShift <= {rxShift[6:0], sdaLevel};
                        end
                        if (phase == 2'h2 && bitIdx == ACK_SLOT && !isRx && sdaLevel) begin
                            nack <= 1'b1;
                        end
                        if (phase == 2'h3) begin
                            sclReg <= 1'b0;
                            bitIdx <= (bitIdx == ACK_SLOT) ? 4'h0 : bitIdx + 4'h1;
                            if (bitIdx == ACK_SLOT && isRx && byteIdx == 2'h1) rxFirst <= rxShift;
                            if (bitIdx == ACK_SLOT && isRx && byteIdx == 2'h2) rxSecond <= rxShift;
                            if (bitIdx == ACK_SLOT && (lastByte || nack)) state <= H_STOP;
                            if (bitIdx == ACK_SLOT) byteIdx <= byteIdx + 2'h1;
                        end
                    end
                    H_STOP: begin
                        if (phase == 2'h0) sdaLow <= 1'b1;
                        if (phase == 2'h1) sclReg <= 1'b1;
                        if (phase == 2'h2) sdaLow <= 1'b0;
                        if (phase == 2'h3) begin
                            busy <= 1'b0;
                            state <= H_IDLE;
                        end
                    end
                    default: state <= H_IDLE;
                endcase
            end
        end
    end

    assign link.scl = sclReg;
    assign link.hostSdaOut = 1'b0;
    assign link.hostSdaOe = sdaLow;
endmodule : pot_host

// ### rtl/pot_link_pkg.sv
// constants shared by both ends of the two-wire potentiometer link
// assumes a 100 MHz system clock and a single-master bus
// Summary of operation
// - start then seven address bits plus direction
// - address 01011 then fixed 11 or straps
// - on address match, pull data low ninth pulse
// - direction one reads, zero writes
// - instruction msb selects channel one or two
// - park bit parks wiper, keeps stored code
// - parked channel still accepts codes, reapplied after
// - fuse bit freezes selected channel setting; the code freezes both channels once a burn leaves the fuse status at FUSE_DONE
// - master sends bit four zero; ignore low bits
// - override bit allows changes after fusing
// - override cleared restores pre-override setting
// - power-up: midscale unfused, else fused code
// - data byte msb first loads wiper code
// - nine pulses per byte; data stable while high
// - read sends selected wiper right after address
// - address plus instruction alone selects readback
// - validation byte top bits give fuse status
// - master ends with stop, nacks last read
// - further data bytes keep updating selected channel
// - repeated reads return current code again
package pot_link_pkg;
    localparam logic [4:0] ADDR_PREFIX = 5'h0b;
    localparam logic [1:0] FIXED_ADDR_LOW = 2'h3;
    localparam logic [7:0] WIPER_MIDSCALE = 8'h80;
    localparam int INSTR_CHAN_BIT = 7;
    localparam int INSTR_PARK_BIT = 6;
    localparam int INSTR_FUSE_BIT = 5;
    localparam int INSTR_OVR_BIT = 3;
    localparam logic [1:0] FUSE_READY = 2'h0;
    localparam logic [1:0] FUSE_DONE = 2'h3;
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCL_QUARTER_NS = 625;
    localparam int SCL_QUARTER_CYCLES = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SLAVE = 8'h04;
    localparam logic [7:0] REG_TX = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_RX = 8'h10;
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_READ_BIT = 1;
    localparam int CTRL_NODATA_BIT = 2;
    localparam logic [6:0] SLAVE_RESET = 7'h2f;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage : pot_link_pkg

// ### rtl/pot_link_if.sv
// two-wire link between the bus master and the potentiometer
// the data line is open drain with a pull-up; the master drives the clock
`timescale 1ns/1ps
interface pot_link_if;
    logic scl;
    logic sda;
    logic hostSdaOut;
    logic hostSdaOe;
    logic devSdaOut;
    logic devSdaOe;

    // wired-and of both drivers over the pull-up
    assign sda = !((hostSdaOe && !hostSdaOut) || (devSdaOe && !devSdaOut));

    modport host (output scl, output hostSdaOut, output hostSdaOe, input sda);
    modport dev (input scl, input sda, output devSdaOut, output devSdaOe);
endinterface : pot_link_if

// ### rtl/line_sampler.sv
// synchronises the two link lines and finds clock edges, start and stop
// lines are asynchronous to sys_clk
`timescale 1ns/1ps
module line_sampler (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // raw lines
    input wire logic sclPin,
    input wire logic sdaPin,
    // sampled view
    output logic sclLevel,
    output logic sdaLevel,
    output logic sclRise,
    output logic sclFall,
    output logic startSeen,
    output logic stopSeen
);
    logic sclMeta, sdaMeta, sclSync, sdaSync, sclPrev, sdaPrev;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            sclMeta <= 1'b1;
            sdaMeta <= 1'b1;
            sclSync <= 1'b1;
            sdaSync <= 1'b1;
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclMeta <= sclPin;
            sdaMeta <= sdaPin;
            sclSync <= sclMeta;
            sdaSync <= sdaMeta;
            sclPrev <= sclSync;
            sdaPrev <= sdaSync;
        end
    end

    assign sclLevel = sclSync;
    assign sdaLevel = sdaSync;
    assign sclRise = sclSync && !sclPrev;
    assign sclFall = !sclSync && sclPrev;
    assign startSeen = sclSync && sclPrev && sdaPrev && !sdaSync;
    assign stopSeen = sclSync && sclPrev && !sdaPrev && sdaSync;
endmodule : line_sampler

// ### rtl/pot_device.sv
// serial command port of a dual-channel fuse-programmable potentiometer
// sits on pot_link_if as the slave; outputs feed the resistor array
`timescale 1ns/1ps
module pot_device
    import pot_link_pkg::*;
#(
    parameter bit FIXED_VARIANT = 1'b1
) (
    // clock and power-up reset
    input wire logic sys_clk,
    input wire logic rstn,
    // blank-die initialisation of the fuse array
    input wire logic otpClearN,
    // address straps, used only when not the fixed variant
    input wire logic [1:0] addrStrap,
    // burn outcome reported by the fuse array, zero means clean
    input wire logic [1:0] fuseBurnFault,
    // link
    pot_link_if.dev link,
    // resistor array side
    output logic [1:0][7:0] wiperCode,
    output logic [1:0] parkActive,
    output logic [1:0] overrideActive,
    output logic [1:0] fuseStatus
);
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_INSTR, ST_INSTR_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK, ST_IGNORE
    } dev_state_e;

    dev_state_e state;
    logic sclLevel, sdaLevel, sclRise, sclFall, startSeen, stopSeen;
    logic [1:0] strapMeta, strapSync, addrLow;
    logic [7:0] shiftReg, txReg;
    logic [3:0] bitCnt;
    logic rxFull, rdMode, selChan, readPhase, sdaLow;
    logic [7:0] wiper [2];
    logic [7:0] savedCode [2];
    logic [7:0] fuseCode [2];
    logic [1:0] park, ovr;

    line_sampler u_sampler (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .sclPin(link.scl),
        .sdaPin(link.sda),
        .sclLevel(sclLevel),
        .sdaLevel(sdaLevel),
        .sclRise(sclRise),
        .sclFall(sclFall),
        .startSeen(startSeen),
        .stopSeen(stopSeen)
    );

    // straps are static, so sampling them continuously is harmless
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            strapMeta <= 2'h0;
            strapSync <= 2'h0;
            addrLow <= FIXED_ADDR_LOW;
        end else begin
            strapMeta <= addrStrap;
            strapSync <= strapMeta;
            addrLow <= FIXED_VARIANT ? FIXED_ADDR_LOW : strapSync;
        end
    end

    wire rxState = (state == ST_ADDR) || (state == ST_INSTR) || (state == ST_WDATA);
    wire byteDone = sclFall && rxFull && rxState;
    wire addrMatch = shiftReg[7:1] == {ADDR_PREFIX, addrLow};
    wire ackThis = (state != ST_ADDR) || addrMatch;
    wire instrTake = byteDone && (state == ST_INSTR);
    wire dataTake = byteDone && (state == ST_WDATA);
    wire fused = fuseStatus == FUSE_DONE;
    // bit 4 and bits 2..0 of the instruction are never looked at
    wire programReq = instrTake && shiftReg[INSTR_FUSE_BIT] && !fused;
    wire [1:0] burnResult = (fuseBurnFault == FUSE_READY) ? FUSE_DONE : fuseBurnFault;
    wire [7:0] selWiper = wiper[selChan];
    wire [7:0] validByte = {fuseStatus, 6'h00};
    wire [7:0] nextTx = readPhase ? validByte : selWiper;

    dev_state_e afterByte;
    assign afterByte = !ackThis ? ST_IGNORE :
                       (state == ST_ADDR) ? ST_ADDR_ACK :
                       (state == ST_INSTR) ? ST_INSTR_ACK : ST_WDATA_ACK;

    // byte engine: sample on clock rise, drive on clock fall
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state <= ST_IDLE;
            shiftReg <= 8'h00;
            txReg <= 8'h00;
            bitCnt <= 4'h0;
            rxFull <= 1'b0;
            rdMode <= 1'b0;
            selChan <= 1'b0;
            readPhase <= 1'b0;
            sdaLow <= 1'b0;
        end else if (startSeen) begin
            // a repeated start is taken from any state
            state <= ST_ADDR;
            bitCnt <= 4'h0;
            rxFull <= 1'b0;
            sdaLow <= 1'b0;
        end else if (stopSeen) begin
            state <= ST_IDLE;
            sdaLow <= 1'b0;
        end else begin
            case (state)
                ST_ADDR, ST_INSTR, ST_WDATA: begin
                    if (sclRise && !rxFull) begin
                        shiftReg <= {shiftReg[6:0], sdaLevel};
                        bitCnt <= bitCnt + 4'h1;
                        rxFull <= (bitCnt == LAST_DATA_BIT);
                    end else if (byteDone) begin
                        rxFull <= 1'b0;
                        bitCnt <= 4'h0;
                        sdaLow <= ackThis;
                        state <= afterByte;
                        if (state == ST_ADDR) begin
                            rdMode <= shiftReg[0];
                        end
                        if (state == ST_INSTR) begin
                            selChan <= shiftReg[INSTR_CHAN_BIT];
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (sclFall && rdMode) begin
                        // first data bit goes out on the same fall that ends ack
                        txReg <= selWiper;
                        sdaLow <= !selWiper[7];
                        readPhase <= 1'b1;
                        bitCnt <= 4'h0;
                        state <= ST_RDATA;
                    end else if (sclFall) begin
                        sdaLow <= 1'b0;
                        state <= ST_INSTR;
                    end
                end
                ST_INSTR_ACK, ST_WDATA_ACK: begin
                    if (sclFall) begin
                        sdaLow <= 1'b0;
                        state <= ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (sclFall && bitCnt == LAST_DATA_BIT) begin
                        sdaLow <= 1'b0;
                        state <= ST_RACK;
                    end else if (sclFall) begin
                        sdaLow <= !txReg[6];
                        txReg <= {txReg[6:0], 1'b0};
                        bitCnt <= bitCnt + 4'h1;
                    end
                end
                ST_RACK: begin
                    if (sclRise && sdaLevel) begin
                        // master declined more bytes; wait for stop
                        state <= ST_IGNORE;
                    end else if (sclFall) begin
                        txReg <= nextTx;
                        sdaLow <= !nextTx[7];
                        readPhase <= !readPhase;
                        bitCnt <= 4'h0;
                        state <= ST_RDATA;
                    end
                end
                default: begin
                    sdaLow <= 1'b0;
                end
            endcase
        end
    end

    // fuse array survives power-up reset; only blank-die init clears it
    always_ff @(posedge sys_clk) begin
        if (!otpClearN) begin
            fuseStatus <= FUSE_READY;
            fuseCode[0] <= WIPER_MIDSCALE;
            fuseCode[1] <= WIPER_MIDSCALE;
        end else if (programReq) begin
            fuseCode[shiftReg[INSTR_CHAN_BIT]] <= wiper[shiftReg[INSTR_CHAN_BIT]];
            fuseStatus <= burnResult;
        end
    end

    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_chan
            wire instrHit = instrTake && (shiftReg[INSTR_CHAN_BIT] == c[0]);
            wire dataHit = dataTake && (selChan == c[0]);
            always_ff @(posedge sys_clk) begin
                if (!rstn) begin
                    // override never survives power-up
                    wiper[c] <= fused ? fuseCode[c] : WIPER_MIDSCALE;
                    savedCode[c] <= WIPER_MIDSCALE;
                    park[c] <= 1'b0;
                    ovr[c] <= 1'b0;
                end else if (instrHit) begin
                    park[c] <= shiftReg[INSTR_PARK_BIT];
                    if (shiftReg[INSTR_OVR_BIT] && !ovr[c]) begin
                        ovr[c] <= 1'b1;
                        savedCode[c] <= wiper[c];
                    end else if (!shiftReg[INSTR_OVR_BIT] && ovr[c]) begin
                        ovr[c] <= 1'b0;
                        wiper[c] <= savedCode[c];
                    end
                end else if (dataHit && (!fused || ovr[c])) begin
                    // parked channels still take codes, so leaving park applies them
                    wiper[c] <= shiftReg;
                end
            end
            assign wiperCode[c] = wiper[c];
        end
    endgenerate

    assign parkActive = park;
    assign overrideActive = ovr;
    assign link.devSdaOut = 1'b0;
    assign link.devSdaOe = sdaLow;
endmodule : pot_device

// ### testbench/pot_link_monitor.sv
// link checker on the interface nets between host and device
// all nets sampled on sys_clk; the host owns scl
`timescale 1ns/1ps
module pot_link_monitor (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // link nets
    input wire logic scl,
    input wire logic sda,
    input wire logic hostSdaOe,
    input wire logic devSdaOut,
    input wire logic devSdaOe
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    sequence sHeld;
        scl [*8];
    endsequence
    sequence sNextRise;
        ##[1:300] $rose(scl);
    endsequence
    // open drain, and data moves only once the clock fall has reached the sampler
    AST_DEV_OD: assert property (!devSdaOut && (!$changed(devSdaOe) || !$past(scl, 3)))
        else $error("dev drives high or moves before clock fall");
    AST_DEV_RISE: assert property ($rose(devSdaOe) |-> !scl)
        else $error("dev pulls in high");
    AST_DEV_HOLD: assert property (scl && $past(scl) |-> $stable(devSdaOe))
        else $error("dev moves in high");
    AST_START: assert property ($fell(sda) && scl |-> !devSdaOe)
        else $error("dev in start");
    AST_SCL_HIGH: assert property ($rose(scl) |-> sHeld)
        else $error("short scl high");
    AST_NO_FIGHT: assert property (scl && devSdaOe |-> !hostSdaOe)
        else $error("both drive");
    // a pulled bit must last past the next clock rise
    AST_ACK: assert property ($rose(devSdaOe) |-> devSdaOe throughout sNextRise)
        else $error("dev let go early");
    AST_RST_IDLE: assert property (disable iff (1'h0) !rstn |=> scl && !devSdaOe)
        else $error("busy in reset");
endmodule : pot_link_monitor

// ### testbench/testbench.sv
// bench: AXI orders to the host, host and device joined by the link
// fixed-address device; bready, rready and wstrb held constant
`timescale 1ns/1ps
module testbench;
    import pot_link_pkg::*;
    logic sys_clk = 1'h0;
    logic rstn = 1'h0;
    logic otpClearN = 1'h0;
    logic [1:0] fuseBurnFault = 2'h0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata, rx, st;
    logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, r, fuseStatus, parkActive, overrideActive, ep;
    logic [1:0][7:0] wiperCode, ew;
    int error_cnt = 0, n_tests = 0, seed = 32'h939a;
    pot_link_if pot_link_if_inst ();
    pot_host #(.QTR(8)) pot_host_inst (.sys_clk, .rstn, .awaddr, .awvalid, .awready, .wdata,
        .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready(1'h1), .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready(1'h1), .link(pot_link_if_inst));
    pot_device pot_device_inst (.sys_clk, .rstn, .otpClearN, .addrStrap(2'h0), .fuseBurnFault,
        .link(pot_link_if_inst), .wiperCode, .parkActive, .overrideActive, .fuseStatus);
    pot_link_monitor pot_link_monitor_inst (.sys_clk, .rstn, .scl(pot_link_if_inst.scl),
        .sda(pot_link_if_inst.sda), .hostSdaOe(pot_link_if_inst.hostSdaOe),
        .devSdaOut(pot_link_if_inst.devSdaOut), .devSdaOe(pot_link_if_inst.devSdaOe));
    initial begin
        forever #5 sys_clk = !sys_clk;
    end
    task automatic stop_test();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test
    task automatic tmo();
        error_cnt++;
        stop_test();
    endtask : tmo
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (e !== g) begin
            $display("wrong value %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask : chk
    // ready sampled at the falling edge, so the take edge is known without a race
    task automatic axi(input logic rd, input logic [7:0] a, input logic [31:0] dt);
        logic fa, fw, fe;
        int t;
        t = 0;
        fe = 1'h0;
        awaddr <= a;
        araddr <= a;
        wdata <= dt;
        awvalid <= !rd;
        wvalid <= !rd;
        arvalid <= rd;
        while (fe !== 1'h1) begin
            @(negedge sys_clk);
            fa = (awvalid && awready) || (arvalid && arready);
            fw = wvalid && wready;
            fe = rd ? rvalid : bvalid;
            r = rd ? rresp : bresp;
            rx = rd ? rdata : rx;
            @(posedge sys_clk);
            if (fa) {awvalid, arvalid} <= 2'h0;
            if (fw) wvalid <= 1'h0;
            t++;
            if (t > 300) tmo();
        end
    endtask : axi
    task automatic xfer(input logic [7:0] i, input logic [7:0] dt, input logic [2:0] ct);
        int t;
        t = 0;
        axi(1'h0, REG_TX, {16'h0, i, dt});
        axi(1'h0, REG_CTRL, {29'h0, ct});
        rx = 32'h1;
        while (rx[0] !== 1'h0) begin
            axi(1'h1, REG_STATUS, 32'h0);
            t++;
            if (t > 2000) tmo();
        end
        st = rx;
        axi(1'h1, REG_RX, 32'h0);
    endtask : xfer
    // junk in the don't-care bits and in bit four must change nothing
    function automatic logic [7:0] ins(input logic ch, input logic pk, input logic fu,
        input logic ov);
        return {ch, pk, fu, 1'($random(seed)), ov, 3'($random(seed))};
    endfunction : ins
    initial begin
        ew = {8'h80, 8'h80};
        ep = 2'h0;
        repeat (11) @(posedge sys_clk);
        otpClearN <= 1'h1;
        @(posedge sys_clk);
        rstn <= 1'h1;
        repeat (4) @(posedge sys_clk);
        chk("wiper", ew, wiperCode);
        for (int k = 0; k < 8; k++) begin
            ew[k[0]] = (k == 0) ? 8'h00 : (k == 7) ? 8'hff : 8'($random(seed));
            ep[k[0]] = k[1];
            xfer(ins(k[0], k[1], 1'h0, 1'h0), ew[k[0]], 3'h1);
            chk("wiper", ew, wiperCode);
            chk("park", ep, parkActive);
        end
        for (int k = 0; k < 2; k++) begin
            ep[k] = 1'h0;
            xfer(ins(k[0], 1'h0, 1'h0, 1'h0), 8'h0, 3'h5);
            xfer(8'h0, 8'h0, 3'h3);
            chk("readback", {ew[k], FUSE_READY, 6'h0}, rx[15:0]);
        end
        chk("park", ep, parkActive);
        axi(1'h0, REG_SLAVE, 32'h2e);
        chk("bresp", AXI_OKAY, r);
        xfer(ins(1'h0, 1'h0, 1'h0, 1'h0), 8'h11, 3'h1);
        chk("nack", 1'h1, st[1]);
        chk("wiper", ew, wiperCode);
        axi(1'h0, REG_SLAVE, {25'h0, SLAVE_RESET});
        axi(1'h1, 8'hfc, 32'h0);
        chk("rresp", AXI_SLVERR, r);
        for (int k = 0; k < 3; k++) begin
            fuseBurnFault <= 2'(8'h21 >> (2 * k));
            xfer(ins(1'h0, 1'h0, 1'h1, 1'h0), 8'h0, 3'h5);
            chk("fuse", 2'(8'h3d >> (2 * k)), fuseStatus);
        end
        xfer(ins(1'h0, 1'h0, 1'h0, 1'h0), 8'h5a, 3'h1);
        chk("wiper", ew, wiperCode);
        xfer(ins(1'h0, 1'h0, 1'h0, 1'h1), 8'h33, 3'h1);
        chk("override", {ew[1], 8'h33, 2'h1}, {wiperCode, overrideActive});
        xfer(ins(1'h0, 1'h0, 1'h0, 1'h0), 8'h0, 3'h5);
        chk("restore", ew, wiperCode);
        xfer(ins(1'h0, 1'h0, 1'h0, 1'h1), 8'h44, 3'h1);
        rstn <= 1'h0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'h1;
        repeat (4) @(posedge sys_clk);
        chk("powerup", {8'h80, ew[0], 2'h0}, {wiperCode, overrideActive});
        stop_test();
    end
endmodule : testbench
